// ===== verilog/xpd_pkg.sv
// ----------------------------------------------------------------
// shared constants for the lane code map and deskew block
// ----------------------------------------------------------------
package xpd_pkg;

  // lane geometry
  localparam int XPD_LANES = 4;
  localparam int XPD_BYTE_W = 8;
  localparam int XPD_CHAR_W = 9;             // control flag plus byte
  localparam int XPD_COL_W = 36;             // four flags, four bytes

  // per-lane deskew store
  localparam int XPD_SKEW_DEPTH = 16;
  localparam int XPD_SKEW_AW = 4;

  // largest spread between /A/ arrivals, in link clock cycles
  localparam logic [3:0] XPD_SKEW_WINDOW = 4'ha;

  // crossing buffer into the system clock domain
  localparam int XPD_XFIFO_DEPTH = 8;

  // special code group values seen after the 8b/10b decoder
  localparam logic [7:0] XPD_K28_0 = 8'h1c;
  localparam logic [7:0] XPD_K28_3 = 8'h7c;  // alignment /A/
  localparam logic [7:0] XPD_K28_4 = 8'h9c;
  localparam logic [7:0] XPD_K28_5 = 8'hbc;
  localparam logic [7:0] XPD_K27_7 = 8'hfb;
  localparam logic [7:0] XPD_K29_7 = 8'hfd;
  localparam logic [7:0] XPD_K30_7 = 8'hfe;

  // characters as presented on the media independent side
  localparam logic [7:0] XPD_CH_IDLE = 8'h07;
  localparam logic [7:0] XPD_CH_SEQ = 8'h9c;
  localparam logic [7:0] XPD_CH_START = 8'hfb;
  localparam logic [7:0] XPD_CH_TERM = 8'hfd;
  localparam logic [7:0] XPD_CH_ERR = 8'hfe;

  // deskew state machine, one-hot
  typedef enum logic [2:0] {
    XPD_WAIT_SYNC = 3'b001,
    XPD_WAIT_A = 3'b010,
    XPD_ALIGNED = 3'b100
  } xpd_state_t;

endpackage

// ===== verilog/xpd_xfifo.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// dual clock fifo with gray coded pointers
// ----------------------------------------------------------------
module xpd_xfifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // filling side
  input wire logic in_clk,
  input wire logic in_rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  input wire logic out_clk,
  input wire logic out_rst_n,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];      // storage, written on in_clk
  logic [AW:0] wbin_ff;                  // write count, binary
  logic [AW:0] wgray_ff;                 // write count, gray
  logic [AW:0] rbin_ff;                  // read count, binary
  logic [AW:0] rgray_ff;                 // read count, gray
  logic [AW:0] rgray_m_ff;               // read gray, first stage
  logic [AW:0] rgray_s_ff;               // read gray, second stage
  logic [AW:0] wgray_m_ff;               // write gray, first stage
  logic [AW:0] wgray_s_ff;               // write gray, second stage
  logic [AW:0] nxt_wbin;
  logic [AW:0] nxt_rbin;
  logic do_wr;
  logic do_rd;

  // ----------------------------------------------------------------
  // write side
  // ----------------------------------------------------------------
  // full when write gray equals read gray with top two bits inverted
  assign in_ready = (wgray_ff !=
    {~rgray_s_ff[AW:AW-1], rgray_s_ff[AW-2:0]});
  assign do_wr = in_valid && in_ready;
  assign nxt_wbin = wbin_ff + 1'b1;

  // write pointer advance
  always_ff @(posedge in_clk) begin
    if (!in_rst_n) begin
      wbin_ff <= '0;
      wgray_ff <= '0;
    end else if (do_wr) begin
      wbin_ff <= nxt_wbin;
      wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
    end
  end

  // storage write
  always_ff @(posedge in_clk) begin
    if (do_wr) begin
      mem_ff[wbin_ff[AW-1:0]] <= in_data;
    end
  end

  // read pointer into write domain
  always_ff @(posedge in_clk) begin
    if (!in_rst_n) begin
      rgray_m_ff <= '0;
      rgray_s_ff <= '0;
    end else begin
      rgray_m_ff <= rgray_ff;
      rgray_s_ff <= rgray_m_ff;
    end
  end

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  assign out_valid = (rgray_ff != wgray_s_ff);
  assign do_rd = out_valid && out_ready;
  assign nxt_rbin = rbin_ff + 1'b1;
  assign out_data = mem_ff[rbin_ff[AW-1:0]];

  // read pointer advance
  always_ff @(posedge out_clk) begin
    if (!out_rst_n) begin
      rbin_ff <= '0;
      rgray_ff <= '0;
    end else if (do_rd) begin
      rbin_ff <= nxt_rbin;
      rgray_ff <= nxt_rbin ^ (nxt_rbin >> 1);
    end
  end

  // write pointer into read domain
  always_ff @(posedge out_clk) begin
    if (!out_rst_n) begin
      wgray_m_ff <= '0;
      wgray_s_ff <= '0;
    end else begin
      wgray_m_ff <= wgray_ff;
      wgray_s_ff <= wgray_m_ff;
    end
  end

endmodule

// ===== verilog/xpd_lane.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// one lane: code group map and deskew store
// ----------------------------------------------------------------
module xpd_lane import xpd_pkg::*; (
  // link clock and reset
  input wire logic link_clk,
  input wire logic link_rst_n,
  // control from the deskew state machine
  input wire logic clr,
  input wire logic arm,
  input wire logic rd_en,
  // decoded code group
  input wire logic [7:0] code_byte,
  input wire logic code_k,
  input wire logic code_err,
  // status and aligned character
  output logic seen_a,
  output logic ovf,
  output logic [XPD_CHAR_W-1:0] col
);

  logic [XPD_CHAR_W-1:0] mem_ff [XPD_SKEW_DEPTH]; // deskew store
  logic [XPD_SKEW_AW:0] wptr_ff;                  // write pointer
  logic [XPD_SKEW_AW:0] rptr_ff;                  // read pointer
  logic [XPD_SKEW_AW:0] fill;                     // words held
  logic seen_ff;                                  // first /A/ taken
  logic is_a;
  logic do_wr;
  logic [XPD_CHAR_W-1:0] nxt_char;                // mapped character

  // ----------------------------------------------------------------
  // code group to character map
  // ----------------------------------------------------------------
  // flag in bit 8, byte below
  always_comb begin
    nxt_char = {1'b1, XPD_CH_ERR};
    if (code_err) begin
      nxt_char = {1'b1, XPD_CH_ERR};
    end else if (!code_k) begin
      nxt_char = {1'b0, code_byte};
    end else begin
      case (code_byte)
        XPD_K28_0, XPD_K28_3, XPD_K28_5: begin
          nxt_char = {1'b1, XPD_CH_IDLE};
        end
        XPD_K28_4: begin
          nxt_char = {1'b1, XPD_CH_SEQ};
        end
        XPD_K27_7: begin
          nxt_char = {1'b1, XPD_CH_START};
        end
        XPD_K29_7: begin
          nxt_char = {1'b1, XPD_CH_TERM};
        end
        XPD_K30_7: begin
          nxt_char = {1'b1, XPD_CH_ERR};
        end
        default: begin
          nxt_char = {1'b1, XPD_CH_ERR};
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // deskew store
  // ----------------------------------------------------------------
  assign is_a = code_k && !code_err && (code_byte == XPD_K28_3);
  // nothing is stored before the first /A/, from then on every word
  assign do_wr = !clr && (seen_ff || (arm && is_a));
  assign seen_a = seen_ff;
  assign fill = wptr_ff - rptr_ff;
  assign ovf = fill[XPD_SKEW_AW];
  assign col = mem_ff[rptr_ff[XPD_SKEW_AW-1:0]];

  // first /A/ marker
  always_ff @(posedge link_clk) begin
    if (!link_rst_n || clr) begin
      seen_ff <= 1'b0;
    end else if (arm && is_a) begin
      seen_ff <= 1'b1;
    end
  end

  // write pointer, frozen until the first /A/
  always_ff @(posedge link_clk) begin
    if (!link_rst_n || clr) begin
      wptr_ff <= '0;
    end else if (do_wr) begin
      wptr_ff <= wptr_ff + 1'b1;
    end
  end

  // storage write
  always_ff @(posedge link_clk) begin
    if (do_wr) begin
      mem_ff[wptr_ff[XPD_SKEW_AW-1:0]] <= nxt_char;
    end
  end

  // read pointer, moves only once all lanes are released
  always_ff @(posedge link_clk) begin
    if (!link_rst_n || clr) begin
      rptr_ff <= '0;
    end else if (rd_en) begin
      rptr_ff <= rptr_ff + 1'b1;
    end
  end

endmodule

// ===== verilog/xpd_top.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// four lane code map and deskew, media independent side
// ----------------------------------------------------------------
// How it works
// - bad transmit control byte becomes K30.7
// - data code group gives flag 0, byte
// - K28.0, K28.3, K28.5 give flag 1, 07
// - K28.4 9C, K27.7 FB, K29.7 FD, K30.7 FE
// - invalid code group gives flag 1, FE
// - deskew waits for sync on all lanes
// - pointers frozen before a lane's first /A/
// - after /A/ writes advance, reads stay frozen
// - all /A/ within 10 cycles releases reads together
module xpd_top import xpd_pkg::*; (
  // system clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // link side, recovered clock and decoded code groups
  input wire logic LINK_CLK,
  input wire logic [31:0] LANE_BYTE,
  input wire logic [3:0] LANE_K,
  input wire logic [3:0] LANE_ERR,
  input wire logic [3:0] LANE_SYNC,
  // aligned receive stream
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic [3:0] RX_CTRL,
  output logic [31:0] RX_DATA,
  output logic ALIGN_LOCK,
  // transmit character map
  input wire logic [3:0] TX_CTRL,
  input wire logic [31:0] TX_DATA,
  output logic [3:0] TX_K,
  output logic [31:0] TX_CODE
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic link_rst_m_ff;                 // reset into link, first stage
  logic link_rst_n_ff;                 // reset into link, second stage
  xpd_state_t state_ff;                // deskew state
  xpd_state_t nxt_state;
  logic [3:0] skew_cnt_ff;             // cycles since first /A/
  logic [3:0] seen;                    // per lane first /A/ taken
  logic [3:0] ovf;                     // per lane store overflow
  logic [XPD_CHAR_W-1:0] lane_col [XPD_LANES]; // aligned characters
  logic all_sync;
  logic any_seen;
  logic all_seen;
  logic timeout;
  logic lose;
  logic clr;
  logic arm;
  logic push;
  logic fifo_in_ready;
  logic [XPD_COL_W-1:0] col_word;      // one aligned column
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [XPD_COL_W-1:0] fifo_out_data;
  logic lock_m_ff;                     // lock into system, first stage
  logic lock_s_ff;                     // lock into system, second stage
  logic rx_valid_ff;                   // output stage holds a column
  logic [3:0] rx_ctrl_ff;
  logic [31:0] rx_data_ff;
  logic [3:0] tx_k_ff;
  logic [31:0] tx_code_ff;
  logic [3:0] nxt_tx_k;
  logic [31:0] nxt_tx_code;

  // ----------------------------------------------------------------
  // reset into the link domain
  // ----------------------------------------------------------------
  // two stages, the link logic reads only the second
  always_ff @(posedge LINK_CLK) begin
    link_rst_m_ff <= NRST;
    link_rst_n_ff <= link_rst_m_ff;
  end

  // ----------------------------------------------------------------
  // lanes
  // ----------------------------------------------------------------
  // one map and deskew store per lane
  for (genvar i = 0; i < XPD_LANES; i++) begin : g_lane
    xpd_lane u_lane (
      .link_clk(LINK_CLK),
      .link_rst_n(link_rst_n_ff),
      .clr(clr),
      .arm(arm),
      .rd_en(push),
      .code_byte(LANE_BYTE[i*8 +: 8]),
      .code_k(LANE_K[i]),
      .code_err(LANE_ERR[i]),
      .seen_a(seen[i]),
      .ovf(ovf[i]),
      .col(lane_col[i])
    );
    // flags in the top nibble, lane 0 in the low byte
    assign col_word[32+i] = lane_col[i][8];
    assign col_word[i*8 +: 8] = lane_col[i][7:0];
  end

  // ----------------------------------------------------------------
  // deskew control, link domain
  // ----------------------------------------------------------------
  assign all_sync = &LANE_SYNC;
  assign any_seen = |seen;
  assign all_seen = &seen;
  // spread of /A/ arrivals grew past the window
  assign timeout = (state_ff == XPD_WAIT_A) && any_seen && !all_seen
    && (skew_cnt_ff == XPD_SKEW_WINDOW);
  // sync dropped, or a store ran full while aligned
  assign lose = (state_ff == XPD_ALIGNED) && (!all_sync || (|ovf));
  // pointers held at zero outside a deskew attempt
  assign clr = (state_ff == XPD_WAIT_SYNC) || timeout || lose
    || ((state_ff == XPD_WAIT_A) && !all_sync);
  assign arm = (state_ff == XPD_WAIT_A) && all_sync && !timeout;
  // every store reads in the same cycle, only while aligned
  assign push = (state_ff == XPD_ALIGNED) && !lose
    && fifo_in_ready;

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      XPD_WAIT_SYNC: begin
        if (all_sync) begin
          nxt_state = XPD_WAIT_A;
        end
      end
      XPD_WAIT_A: begin
        if (!all_sync) begin
          nxt_state = XPD_WAIT_SYNC;
        end else if (all_seen) begin
          nxt_state = XPD_ALIGNED;
        end
      end
      XPD_ALIGNED: begin
        if (lose) begin
          nxt_state = XPD_WAIT_SYNC;
        end
      end
      default: begin
        nxt_state = XPD_WAIT_SYNC;
      end
    endcase
  end

  // state register
  always_ff @(posedge LINK_CLK) begin
    if (!link_rst_n_ff) begin
      state_ff <= XPD_WAIT_SYNC;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // skew window counter, starts with the first lane's /A/
  always_ff @(posedge LINK_CLK) begin
    if (!link_rst_n_ff || clr || !any_seen) begin
      skew_cnt_ff <= '0;
    end else if ((state_ff == XPD_WAIT_A)
                 && (skew_cnt_ff != XPD_SKEW_WINDOW)) begin
      skew_cnt_ff <= skew_cnt_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // crossing into the system domain
  // ----------------------------------------------------------------
  // a full buffer stalls all read pointers together
  xpd_xfifo #(
    .WIDTH(XPD_COL_W),
    .DEPTH(XPD_XFIFO_DEPTH)
  ) u_xfifo (
    .in_clk(LINK_CLK),
    .in_rst_n(link_rst_n_ff),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(col_word),
    .out_clk(SYS_CLK),
    .out_rst_n(NRST),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // output stage takes a column when empty or being drained
  assign fifo_out_ready = !rx_valid_ff || RX_READY;

  // output valid
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      rx_valid_ff <= 1'b0;
    end else if (fifo_out_ready) begin
      rx_valid_ff <= fifo_out_valid;
    end
  end

  // output column
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      rx_ctrl_ff <= '0;
      rx_data_ff <= '0;
    end else if (fifo_out_ready && fifo_out_valid) begin
      rx_ctrl_ff <= fifo_out_data[35:32];
      rx_data_ff <= fifo_out_data[31:0];
    end
  end

  // alignment state as a level in the system domain
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      lock_m_ff <= 1'b0;
      lock_s_ff <= 1'b0;
    end else begin
      lock_m_ff <= (state_ff == XPD_ALIGNED);
      lock_s_ff <= lock_m_ff;
    end
  end

  assign RX_VALID = rx_valid_ff;
  assign RX_CTRL = rx_ctrl_ff;
  assign RX_DATA = rx_data_ff;
  assign ALIGN_LOCK = lock_s_ff;

  // ----------------------------------------------------------------
  // transmit character map
  // ----------------------------------------------------------------
  // control characters pass, unknown ones become the error group
  always_comb begin
    nxt_tx_k = TX_CTRL;
    nxt_tx_code = TX_DATA;
    for (int i = 0; i < XPD_LANES; i++) begin
      if (TX_CTRL[i]) begin
        case (TX_DATA[i*8 +: 8])
          XPD_CH_IDLE, XPD_CH_SEQ, XPD_CH_START, XPD_CH_TERM,
          XPD_CH_ERR: begin
            nxt_tx_code[i*8 +: 8] = TX_DATA[i*8 +: 8];
          end
          default: begin
            nxt_tx_code[i*8 +: 8] = XPD_K30_7;
          end
        endcase
      end
    end
  end

  // registered transmit characters
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      tx_k_ff <= '0;
      tx_code_ff <= '0;
    end else begin
      tx_k_ff <= nxt_tx_k;
      tx_code_ff <= nxt_tx_code;
    end
  end

  assign TX_K = tx_k_ff;
  assign TX_CODE = tx_code_ff;

endmodule

// ===== verif/xpd_top_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the lane code map and deskew block
// ----------------------------------------------------------------
module xpd_top_monitor import xpd_pkg::*; (
  // clocks and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic LINK_CLK,
  // link side
  input wire logic [31:0] LANE_BYTE,
  input wire logic [3:0] LANE_K,
  input wire logic [3:0] LANE_ERR,
  input wire logic [3:0] LANE_SYNC,
  // receive stream
  input wire logic RX_VALID,
  input wire logic RX_READY,
  input wire logic [3:0] RX_CTRL,
  input wire logic [31:0] RX_DATA,
  input wire logic ALIGN_LOCK,
  // transmit map
  input wire logic [3:0] TX_CTRL,
  input wire logic [31:0] TX_DATA,
  input wire logic [3:0] TX_K,
  input wire logic [31:0] TX_CODE
);
  // byte known as a control character
  function automatic logic known(logic [7:0] b);
    known = b inside {8'h07, 8'h9c, 8'hfb, 8'hfd, 8'hfe};
  endfunction
  // expected encoder bytes: unknown control bytes become the error code
  function automatic logic [31:0] tx_map(logic [3:0] c, logic [31:0] d);
    for (int i = 0; i < 4; i++) begin
      tx_map[8*i+:8] = (c[i] && !known(d[8*i+:8])) ? 8'hfe : d[8*i+:8];
    end
  endfunction
  // every flagged receive byte is a known control character
  function automatic logic ctl_ok(logic [3:0] c, logic [31:0] d);
    ctl_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (c[i] && !known(d[8*i+:8])) ctl_ok = 1'b0;
    end
  endfunction
  logic fresh_ff;  // no column taken since reset
  // clears on the first accepted column
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) fresh_ff <= 1'b1;
    else if (RX_VALID && RX_READY) fresh_ff <= 1'b0;
  end
  // link steps: settled sync, one aligned /A/ column, sync lost
  sequence link_up;
    (NRST && &LANE_SYNC)[*6];
  endsequence
  sequence a_col;
    &LANE_SYNC && LANE_K == 4'hf && LANE_ERR == 4'h0 &&
      LANE_BYTE == 32'h7c7c7c7c;
  endsequence
  sequence link_down;
    (!(&LANE_SYNC))[*4];
  endsequence
  tx_map_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $past(NRST) |-> TX_K == $past(TX_CTRL) &&
      TX_CODE == tx_map($past(TX_CTRL), $past(TX_DATA)))
    else $error("transmit map wrong");
  tx_err_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    TX_CTRL[0] && !known(TX_DATA[7:0]) |=> TX_K[0] && TX_CODE[7:0] == 8'hfe)
    else $error("bad control byte not sent as error");
  rx_wait_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    RX_VALID && !RX_READY |=> RX_VALID)
    else $error("column dropped while stalled");
  rx_hold_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    RX_VALID && !RX_READY |=> $stable(RX_DATA) && $stable(RX_CTRL))
    else $error("column changed while stalled");
  rx_ctrl_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    RX_VALID |-> ctl_ok(RX_CTRL, RX_DATA))
    else $error("flagged byte not a control character");
  rx_first_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    fresh_ff && RX_VALID |-> RX_CTRL == 4'hf && RX_DATA == 32'h07070707)
    else $error("first column is not the alignment column");
  lock_after_a: assert property (@(posedge LINK_CLK) disable iff (!NRST)
    link_up ##1 a_col ##1 (&LANE_SYNC)[*3] |-> ALIGN_LOCK)
    else $error("no lock after aligned column");
  unlock_a: assert property (@(posedge LINK_CLK) disable iff (!NRST)
    link_down |-> !ALIGN_LOCK)
    else $error("lock held without sync");
endmodule

bind xpd_top xpd_top_monitor mon (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .LINK_CLK(LINK_CLK),
  .LANE_BYTE(LANE_BYTE), .LANE_K(LANE_K), .LANE_ERR(LANE_ERR),
  .LANE_SYNC(LANE_SYNC), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
  .RX_CTRL(RX_CTRL), .RX_DATA(RX_DATA), .ALIGN_LOCK(ALIGN_LOCK),
  .TX_CTRL(TX_CTRL), .TX_DATA(TX_DATA), .TX_K(TX_K), .TX_CODE(TX_CODE)
);

// ===== verif/xpd_lane_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far end: four decoded lanes with per-lane medium skew
// ----------------------------------------------------------------
module xpd_lane_model import xpd_pkg::*; #(
  parameter int A_PER = 32
) (
  // link clock and reset
  input wire logic link_clk,
  input wire logic rst_n,
  // controls from the bench
  input wire logic [3:0] sync_set,
  input wire logic [15:0] skew,
  input wire logic kmode,
  // decoded lane outputs
  output logic [31:0] lane_byte,
  output logic [3:0] lane_k,
  output logic [3:0] lane_err,
  output logic [3:0] lane_sync
);
  logic [7:0] j_ff;  // position within the /A/ period
  logic [39:0] hist_ff [16] = '{default: '0};  // recent columns
  logic [39:0] nxt_col;  // column sent this cycle
  // one lane character as err, k, byte
  function automatic logic [9:0] gen(logic [7:0] j, int i, logic km);
    logic [7:0] tbl [9];
    // no second K28.3 in a period: a lane could lock onto it instead of /A/
    tbl = '{8'h1c, 8'h1c, 8'hbc, 8'h9c, 8'hfb, 8'hfd, 8'hfe, 8'hf7, 8'h55};
    if (j == 8'h00) gen = {2'b01, XPD_K28_3};
    else if (km && j < 8'h0a) gen = {j == 8'h09, j != 8'h09, tbl[j-1]};
    else gen = {2'b00, 8'(j + 8'h40 * i)};
  endfunction
  // lanes step through the period together, /A/ at once on all four, data bytes differ per lane
  always_comb begin
    for (int i = 0; i < 4; i++) nxt_col[10*i+:10] = gen(j_ff, i, kmode);
  end
  // period counter
  always_ff @(posedge link_clk) begin
    if (!rst_n) j_ff <= 8'h00;
    else j_ff <= (j_ff == 8'(A_PER - 1)) ? 8'h00 : j_ff + 8'h01;
  end
  // delay line of columns, lane i taps its skew nibble plus one cycles back
  always @(posedge link_clk) begin
    hist_ff[0] <= nxt_col;
    for (int n = 1; n < 16; n++) hist_ff[n] <= hist_ff[n-1];
  end
  // lane outputs after the medium
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      {lane_err[i], lane_k[i], lane_byte[8*i+:8]} =
        hist_ff[skew[4*i+:4]][10*i+:10];
    end
  end
  assign lane_sync = sync_set;
endmodule

// ===== verif/xpd_top_test.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bench for the lane code map and deskew block
// ----------------------------------------------------------------
module xpd_top_test;
  localparam int A_PER = 32;
  logic SYS_CLK, NRST, LINK_CLK, RX_READY, RX_VALID, ALIGN_LOCK, kmode;
  logic [31:0] LANE_BYTE, TX_DATA, RX_DATA, TX_CODE;
  logic [3:0] LANE_K, LANE_ERR, LANE_SYNC, TX_CTRL, RX_CTRL, TX_K;
  logic [3:0] sync_set;  // per lane sync from the far end
  logic [15:0] skew;  // per lane delay in link cycles
  int n_errors, tests_run;
  // system clock, 20 ns
  initial SYS_CLK = 1'b0;
  always #10 SYS_CLK = ~SYS_CLK;
  // link clock, 160 ns, offset from the system clock
  initial begin
    LINK_CLK = 1'b0;
    #7;
    forever #80 LINK_CLK = ~LINK_CLK;
  end
  xpd_top dut (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .LINK_CLK(LINK_CLK),
    .LANE_BYTE(LANE_BYTE), .LANE_K(LANE_K), .LANE_ERR(LANE_ERR),
    .LANE_SYNC(LANE_SYNC), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
    .RX_CTRL(RX_CTRL), .RX_DATA(RX_DATA), .ALIGN_LOCK(ALIGN_LOCK),
    .TX_CTRL(TX_CTRL), .TX_DATA(TX_DATA), .TX_K(TX_K), .TX_CODE(TX_CODE));
  xpd_lane_model #(.A_PER(A_PER)) far (
    .link_clk(LINK_CLK), .rst_n(NRST), .sync_set(sync_set), .skew(skew),
    .kmode(kmode), .lane_byte(LANE_BYTE), .lane_k(LANE_K),
    .lane_err(LANE_ERR), .lane_sync(LANE_SYNC));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [35:0] got,
                       input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h got %h", what, exp, got);
    end
  endtask
  task automatic timeout(input string what);
    n_errors++;
    $display("ERROR %s expected done got timeout", what);
    finish_test();
  endtask
  // reset spans several link cycles so both sides see it
  task automatic do_reset;
    NRST = 1'b0;
    repeat (25) @(negedge SYS_CLK);
    NRST = 1'b1;
  endtask
  task automatic wait_lock(input logic want, input int lim);
    int n;
    n = 0;
    while (ALIGN_LOCK !== want && n < lim) begin
      @(negedge SYS_CLK);
      n++;
    end
    if (ALIGN_LOCK !== want) timeout("align lock");
  endtask
  // lock and stream must stay quiet for a while
  task automatic hold_off(input int cyc);
    logic bad;
    bad = 1'b0;
    repeat (cyc) begin
      @(negedge SYS_CLK);
      if (ALIGN_LOCK !== 1'b0 || RX_VALID !== 1'b0) bad = 1'b1;
    end
    check("lock held off", {35'h0, bad}, 36'h0);
  endtask
  // column expected j places after the alignment column
  function automatic logic [35:0] exp_col(int j);
    logic [7:0] rx [9];
    logic [35:0] c;
    rx = '{8'h07, 8'h07, 8'h07, 8'h9c, 8'hfb, 8'hfd, 8'hfe, 8'hfe, 8'hfe};
    if (j == 0) c = {4'hf, 32'h07070707};
    else if (kmode && j < 10) c = {4'hf, {4{rx[j-1]}}};
    else begin
      c[35:32] = 4'h0;
      for (int i = 0; i < 4; i++) c[8*i+:8] = 8'(j + 64 * i);
    end
    exp_col = c;
  endfunction
  // take n columns with the consumer stalling every third cycle
  task automatic check_cols(input int n);
    int j, got_n, lim;
    j = 0;
    got_n = 0;
    lim = 0;
    while (got_n < n && lim < 4000) begin
      @(negedge SYS_CLK);
      lim++;
      RX_READY = (lim % 3 != 0);
      if (RX_VALID === 1'b1 && RX_READY) begin
        check("rx column", {RX_CTRL, RX_DATA}, exp_col(j));
        j = (j + 1) % A_PER;
        got_n++;
      end
    end
    RX_READY = 1'b1;
    if (got_n < n) timeout("rx columns");
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // back to back transmit characters, known and unknown
  task automatic test_tx;
    logic [7:0] ti [8];
    logic [7:0] to [8];
    logic [3:0] c;
    logic [31:0] d, e;
    ti = '{8'h07, 8'h9c, 8'hfb, 8'hfd, 8'hfe, 8'h55, 8'h00, 8'h7c};
    to = '{8'h07, 8'h9c, 8'hfb, 8'hfd, 8'hfe, 8'hfe, 8'hfe, 8'hfe};
    for (int k = 0; k < 8; k++) begin
      c = {k[0], 3'b111};
      for (int i = 0; i < 4; i++) begin
        d[8*i+:8] = ti[(k+i)%8];
        e[8*i+:8] = c[i] ? to[(k+i)%8] : ti[(k+i)%8];
      end
      TX_CTRL = c;
      TX_DATA = d;
      @(negedge SYS_CLK);
      check("tx char", {TX_K, TX_CODE}, {c, e});
    end
  endtask
  // spread of exactly 10 cycles, control codes and an invalid group
  task automatic test_skew_ok;
    kmode = 1'b1;
    skew = 16'h740a;
    do_reset();
    wait_lock(1'b1, 3000);
    check_cols(40);
  endtask
  // one lane without sync, then sync, then sync lost
  task automatic test_sync;
    kmode = 1'b0;
    skew = 16'h0000;
    sync_set = 4'b0111;
    do_reset();
    hold_off(800);
    sync_set = 4'hf;
    wait_lock(1'b1, 1000);
    check_cols(4);
    sync_set = 4'b1011;
    wait_lock(1'b0, 200);
    sync_set = 4'hf;
    wait_lock(1'b1, 1000);
    check_cols(4);
  endtask
  // spread of 11 never aligns, a fresh spread of 3 does
  task automatic test_late;
    kmode = 1'b0;
    skew = 16'h32b0;
    do_reset();
    hold_off(800);
    skew = 16'h3210;
    wait_lock(1'b1, 1500);
    check_cols(34);
  endtask
  // main sequence
  initial begin
    NRST = 1'b0;
    RX_READY = 1'b1;
    TX_CTRL = 4'h0;
    TX_DATA = 32'h0;
    sync_set = 4'hf;
    skew = 16'h0000;
    kmode = 1'b0;
    n_errors = 0;
    tests_run = 0;
    do_reset();
    test_tx();
    test_skew_ok();
    test_sync();
    test_late();
    finish_test();
  end
endmodule
